// *** include/tcs_pkg.sv ***
// Constants shared by both ends of the touch conversion sequencer link.
// Assumes a 20 MHz reference clock on each end.
package tcs_pkg;
  localparam int unsigned REF_CLK_HZ = 20_000_000;
  localparam int unsigned OSC_HZ = 4_000_000;
  localparam int unsigned CONVERSION_CLOCK_DIV = REF_CLK_HZ / OSC_HZ;
  localparam int unsigned CONV_CYC_12 = 19;
  localparam int unsigned CONV_CYC_8 = 16;
  localparam int unsigned CONV_REPS = 7;
  localparam int unsigned FILT_CYC = 19;
  localparam int unsigned OVERLAP_CYC = 4;
  localparam int unsigned TRIM_DIV = CONV_REPS - 2;
  localparam int unsigned DIV_STEPS = 15;
  localparam int unsigned WR_SCL = 20;
  localparam int unsigned RD12_SCL = 29;
  localparam int unsigned RD8_SCL = 20;
  localparam int unsigned RES_W = 12;
  localparam int unsigned WORD_W = RES_W + 1;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FN_LSB = 4;
  localparam int unsigned MODE_BIT = 1;
  localparam int unsigned FILT_BIT = 1;
  // Bus address value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [3:0] SETUP_FN = 4'hB;
  localparam logic [7:0] NO_DATA_BYTE = 8'hFF;
  localparam logic [11:0] FULL_MASK = 12'hFFF;
  localparam logic [11:0] RES8_MASK = 12'hFF0;
endpackage

// *** include/tcs_link_if.sv ***
// Two-wire serial link between host and converter.
// Assumes both ends drive SDA open drain; the pull-up is modelled here.
`timescale 1ns/1ps
interface tcs_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire sda;
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

// *** design/tcs_device.sv ***
// Converter end: sequencer on the reference clock, serial slave on the link clock.
// Assumes the host toggles SCL while reset is held so the link side resets.
`timescale 1ns/1ps
module tcs_fifo #(
  parameter int unsigned W = 13,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign o_in_ready = cnt_q != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tcs_fifo

////////////////////////////////////////////////////////////////////////////////
module tcs_device (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [tcs_pkg::RES_W-1:0] i_adc_data,
  output logic o_sample_strobe,
  output logic o_busy,
  output logic o_filter_bypass,
  output logic o_res_8bit,
  tcs_link_if.dev link
);
  import tcs_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_ARMED, S_CONV, S_FILT, S_PUSH} tcs_seq_t;
  typedef enum logic [2:0] {L_END, L_SKIP, L_ADDR, L_ADDR_ACK, L_CMD, L_CMD_ACK, L_TX, L_TX_ACK} tcs_lnk_t;
  localparam int unsigned DW = $clog2(CONVERSION_CLOCK_DIV);

  //////////////////////////////////////////////////////////////////////////////
  // Reference domain: pin and handshake synchronisers
  logic [1:0] scl_sync_q, sda_sync_q, cmd_sync_q, ack_sync_q;
  logic sda_prev_q, cmd_seen_q, req_tgl_q;
  logic [WORD_W-1:0] hold_word_q;
  logic bus_start, bus_stop, new_cmd, hold_full;
  // Link-domain registers read across
  logic [7:0] cmd_q;
  logic cmd_tgl_q, ack_tgl_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sda_prev_q <= 1'b1;
      cmd_sync_q <= 2'h0;
      ack_sync_q <= 2'h0;
      cmd_seen_q <= 1'b0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      sda_prev_q <= sda_sync_q[1];
      cmd_sync_q <= {cmd_sync_q[0], cmd_tgl_q};
      ack_sync_q <= {ack_sync_q[0], ack_tgl_q};
      cmd_seen_q <= cmd_sync_q[1];
    end
  end
  assign bus_start = scl_sync_q[1] && sda_prev_q && !sda_sync_q[1];
  assign bus_stop = scl_sync_q[1] && !sda_prev_q && sda_sync_q[1];
  assign new_cmd = cmd_sync_q[1] ^ cmd_seen_q;
  // Command byte is stable for a whole frame once its toggle is seen
  assign hold_full = req_tgl_q ^ ack_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Conversion clock from the reference clock
  logic [DW-1:0] div_q;
  logic tick;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end
  assign tick = div_q == DW'(CONVERSION_CLOCK_DIV - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Setup state and sequencer
  tcs_seq_t seq_q;
  logic bypass_q, res8_q, strobe_q;
  logic [4:0] cyc_q, conv_len, cyc_end;
  logic [2:0] rep_q, last_rep;
  logic [11:0] samp, result_q;
  logic [14:0] sum_q, dvd_q, quo_q;
  logic [11:0] min_q, max_q;
  logic [3:0] rem_q, rtry;
  logic conv_done, filt_done, fifo_ready, rtry_ge;

  always_comb begin
    conv_len = res8_q ? 5'(CONV_CYC_8) : 5'(CONV_CYC_12);
    cyc_end = (rep_q == 3'h0) ? conv_len - 5'(OVERLAP_CYC) : conv_len;
    last_rep = bypass_q ? 3'h0 : 3'(CONV_REPS - 1);
    samp = i_adc_data & (res8_q ? RES8_MASK : FULL_MASK);
    rtry = {rem_q[2:0], dvd_q[14]};
    rtry_ge = rtry >= 4'(TRIM_DIV);
  end
  assign conv_done = (seq_q == S_CONV) && tick && (cyc_q == cyc_end - 5'h1);
  assign filt_done = (seq_q == S_FILT) && tick && (cyc_q == 5'(FILT_CYC - 1));

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      bypass_q <= 1'b0;
      res8_q <= 1'b0;
    end else if (new_cmd && seq_q inside {S_IDLE, S_ARMED}) begin
      if (cmd_q[7:FN_LSB] == SETUP_FN) begin
        bypass_q <= cmd_q[FILT_BIT];
      end else begin
        res8_q <= cmd_q[MODE_BIT];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      seq_q <= S_IDLE;
      cyc_q <= '0;
      rep_q <= '0;
    end else begin
      unique case (seq_q)
        S_IDLE, S_ARMED: begin
          if (new_cmd) begin
            seq_q <= (cmd_q[7:FN_LSB] == SETUP_FN) ? seq_q : S_ARMED;
          end else if (seq_q == S_ARMED && (bus_stop || bus_start)) begin
            seq_q <= S_CONV;
            cyc_q <= '0;
            rep_q <= '0;
          end
        end
        S_CONV: begin
          if (conv_done) begin
            cyc_q <= '0;
            rep_q <= rep_q + 3'h1;
            if (rep_q == last_rep) begin
              seq_q <= bypass_q ? S_PUSH : S_FILT;
            end
          end else if (tick) begin
            cyc_q <= cyc_q + 5'h1;
          end
        end
        S_FILT: begin
          if (filt_done) begin
            seq_q <= S_PUSH;
          end else if (tick) begin
            cyc_q <= cyc_q + 5'h1;
          end
        end
        S_PUSH: begin
          // A full FIFO stalls the sequencer here
          if (fifo_ready) begin
            seq_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Trimmed mean: drop lowest and highest of seven, divide the rest by five
  always_ff @(posedge i_ref_clk) begin
    if (conv_done) begin
      sum_q <= (rep_q == 3'h0) ? {3'h0, samp} : sum_q + {3'h0, samp};
      min_q <= (rep_q == 3'h0 || samp < min_q) ? samp : min_q;
      max_q <= (rep_q == 3'h0 || samp > max_q) ? samp : max_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (seq_q == S_FILT && tick) begin
      if (cyc_q == 5'h0) begin
        dvd_q <= sum_q - {3'h0, min_q} - {3'h0, max_q};
        rem_q <= '0;
        quo_q <= '0;
      end else if (cyc_q <= 5'(DIV_STEPS)) begin
        dvd_q <= {dvd_q[13:0], 1'b0};
        rem_q <= rtry_ge ? rtry - 4'(TRIM_DIV) : rtry;
        quo_q <= {quo_q[13:0], rtry_ge};
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      result_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= conv_done;
      if (conv_done && bypass_q) begin
        result_q <= samp;
      end else if (filt_done) begin
        result_q <= quo_q[11:0] & (res8_q ? RES8_MASK : FULL_MASK);
      end
    end
  end

  assign o_sample_strobe = strobe_q;
  assign o_busy = seq_q != S_IDLE;
  assign o_filter_bypass = bypass_q;
  assign o_res_8bit = res8_q;

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer and hand-off word to the link domain
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  tcs_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_in_valid(seq_q == S_PUSH),
    .o_in_ready(fifo_ready),
    .i_in_data({res8_q, result_q}),
    .o_out_valid(fifo_valid),
    .i_out_ready(!hold_full),
    .o_out_data(fifo_data)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      req_tgl_q <= 1'b0;
      hold_word_q <= '0;
    end else if (fifo_valid && !hold_full) begin
      hold_word_q <= fifo_data;
      req_tgl_q <= !req_tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: bits sampled on SCL rise, state and SDA updated on SCL fall
  tcs_lnk_t lst_q;
  logic [1:0] lrst_q, req_sync_q;
  logic sda_pos_q, drv_q, rw_q, bidx_q, avail;
  logic [2:0] cnt_q;
  logic [7:0] sh_q, tx_q, addr_byte, rd_byte;
  logic [WORD_W-1:0] last_word_q, rd_word;

  // Reset reaches the link side as a level from the reference side: the link clock stands
  // still after release, so a synchroniser on it would swallow the first frame
  always_ff @(posedge i_ref_clk) begin
    lrst_q <= {lrst_q[0], i_nrst};
  end
  always_ff @(negedge link.scl) begin
    req_sync_q <= {req_sync_q[0], req_tgl_q};
  end
  always_ff @(posedge link.scl) begin
    sda_pos_q <= link.sda;
  end

  assign addr_byte = {sh_q[6:0], sda_pos_q};
  assign avail = req_sync_q[1] ^ ack_tgl_q;
  // The hold word is frozen while its request toggle is outstanding
  assign rd_word = avail ? hold_word_q : last_word_q;
  assign rd_byte = (!bidx_q && !last_word_q[RES_W]) ? {last_word_q[3:0], 4'h0} : NO_DATA_BYTE;

  always_ff @(negedge link.scl) begin
    if (!lrst_q[1]) begin
      lst_q <= L_END;
      cnt_q <= '0;
      sh_q <= '0;
      tx_q <= '0;
      drv_q <= 1'b0;
      rw_q <= 1'b0;
      bidx_q <= 1'b0;
      cmd_q <= '0;
      cmd_tgl_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      last_word_q <= '0;
    end else if (lst_q == L_END || (sda_pos_q && !link.sda)) begin
      // After a frame ends the next fall can only follow a start
      lst_q <= L_ADDR;
      cnt_q <= '0;
      drv_q <= 1'b0;
    end else begin
      unique case (lst_q)
        L_SKIP: drv_q <= 1'b0;
        L_ADDR, L_CMD: begin
          sh_q <= addr_byte;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            if (lst_q == L_CMD) begin
              cmd_q <= addr_byte;
              cmd_tgl_q <= !cmd_tgl_q;
              drv_q <= 1'b1;
              lst_q <= L_CMD_ACK;
            end else if (addr_byte[7:1] == DEV_ADDR) begin
              rw_q <= addr_byte[0];
              drv_q <= 1'b1;
              lst_q <= L_ADDR_ACK;
            end else begin
              lst_q <= L_SKIP;
            end
          end
        end
        L_ADDR_ACK: begin
          cnt_q <= '0;
          bidx_q <= 1'b0;
          if (rw_q) begin
            tx_q <= rd_word[11:4];
            drv_q <= !rd_word[11];
            last_word_q <= rd_word;
            ack_tgl_q <= req_sync_q[1];
            lst_q <= L_TX;
          end else begin
            drv_q <= 1'b0;
            lst_q <= L_CMD;
          end
        end
        L_CMD_ACK: begin
          drv_q <= 1'b0;
          lst_q <= L_END;
        end
        L_TX: begin
          cnt_q <= cnt_q + 3'h1;
          tx_q <= {tx_q[6:0], 1'b0};
          drv_q <= (cnt_q == 3'h7) ? 1'b0 : !tx_q[6];
          lst_q <= (cnt_q == 3'h7) ? L_TX_ACK : L_TX;
        end
        L_TX_ACK: begin
          if (!sda_pos_q) begin
            tx_q <= rd_byte;
            drv_q <= !rd_byte[7];
            bidx_q <= 1'b1;
            lst_q <= L_TX;
          end else begin
            drv_q <= 1'b0;
            lst_q <= L_END;
          end
        end
        default: lst_q <= L_END;
      endcase
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = drv_q;
endmodule // tcs_device

// *** design/tcs_host.sv ***
// Host end: two-wire bus master that writes commands and reads results.
// Assumes SCL_HALF reference cycles per SCL half period are enough for the device.
`timescale 1ns/1ps
module tcs_host #(
  parameter int unsigned SCL_HALF = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_wr_req,
  input wire logic [7:0] i_wr_cmd,
  input wire logic i_rd_req,
  input wire logic i_rd_8bit,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic o_rd_valid,
  output logic [tcs_pkg::RES_W-1:0] o_rd_data,
  tcs_link_if.host link
);
  import tcs_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_STOP_LOW, H_STOP_HIGH, H_STOP_REL} tcs_hst_t;
  if (SCL_HALF < 4 || SCL_HALF > 255) begin : g_bad_half
    $error("SCL_HALF must lie in 4..255");
  end

  tcs_hst_t st_q;
  logic [7:0] hc_q;
  logic [1:0] sda_sync_q;
  logic [26:0] stream_q, rx_q;
  logic [4:0] bits_q;
  logic scl_q, drv_q, rd_q, r8_q, done_q, nack_q, rdv_q, half_end;
  logic [11:0] data_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      sda_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], link.sda};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || st_q == H_IDLE || half_end) begin
      hc_q <= '0;
    end else begin
      hc_q <= hc_q + 8'h1;
    end
  end
  assign half_end = hc_q == 8'(SCL_HALF - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer; bits that the device drives are sent as released ones
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st_q <= H_IDLE;
      // Clocks the device link side through its reset; a branch so an unset start value still toggles
      if (scl_q) begin
        scl_q <= 1'b0;
      end else begin
        scl_q <= 1'b1;
      end
      drv_q <= 1'b0;
      stream_q <= '0;
      rx_q <= '0;
      bits_q <= '0;
      rd_q <= 1'b0;
      r8_q <= 1'b0;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          scl_q <= 1'b1;
          if (i_wr_req || i_rd_req) begin
            st_q <= H_START;
            drv_q <= 1'b1;
            rd_q <= !i_wr_req;
            r8_q <= i_rd_8bit;
            if (i_wr_req) begin
              stream_q <= {DEV_ADDR, 1'b0, 1'b1, i_wr_cmd, 1'b1, 9'h1FF};
              bits_q <= 5'(WR_SCL - 2);
            end else if (i_rd_8bit) begin
              stream_q <= {DEV_ADDR, 1'b1, 1'b1, 8'hFF, 1'b1, 9'h1FF};
              bits_q <= 5'(RD8_SCL - 2);
            end else begin
              stream_q <= {DEV_ADDR, 1'b1, 1'b1, 8'hFF, 1'b0, 8'hFF, 1'b1};
              bits_q <= 5'(RD12_SCL - 2);
            end
          end
        end
        H_START, H_LOW: begin
          // Data moves one cycle after the clock falls, so the slave never sees it change with the edge
          if (st_q == H_LOW && hc_q == 8'h00) begin
            drv_q <= !stream_q[26];
          end
          if (half_end) begin
            scl_q <= (st_q == H_LOW);
            st_q <= (st_q == H_LOW) ? H_HIGH : H_LOW;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            rx_q <= {rx_q[25:0], sda_sync_q[1]};
            stream_q <= {stream_q[25:0], 1'b1};
            bits_q <= bits_q - 5'h1;
            scl_q <= 1'b0;
            st_q <= (bits_q == 5'h1) ? H_STOP_LOW : H_LOW;
          end
        end
        H_STOP_LOW: begin
          if (hc_q == 8'h00) begin
            drv_q <= 1'b1;
          end
          if (half_end) begin
            scl_q <= 1'b1;
            st_q <= H_STOP_HIGH;
          end
        end
        H_STOP_HIGH: begin
          if (half_end) begin
            drv_q <= 1'b0;
            st_q <= H_STOP_REL;
          end
        end
        H_STOP_REL: begin
          if (half_end) begin
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      done_q <= 1'b0;
      rdv_q <= 1'b0;
      nack_q <= 1'b0;
      data_q <= '0;
    end else begin
      done_q <= (st_q == H_STOP_REL) && half_end;
      rdv_q <= (st_q == H_STOP_REL) && half_end && rd_q;
      if ((st_q == H_STOP_REL) && half_end) begin
        if (!rd_q) begin
          nack_q <= rx_q[9] || rx_q[0];
        end else if (r8_q) begin
          nack_q <= rx_q[9];
          data_q <= {rx_q[8:1], 4'h0};
        end else begin
          nack_q <= rx_q[18];
          data_q <= {rx_q[17:10], rx_q[8:5]};
        end
      end
    end
  end

  assign o_busy = st_q != H_IDLE;
  assign o_done = done_q;
  assign o_rd_valid = rdv_q;
  assign o_nack = nack_q;
  assign o_rd_data = data_q;
  assign link.scl = scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = drv_q;
endmodule // tcs_host

// *** tb/tcs_link_properties.sv ***
// Checker for the serial link: frame lengths, acknowledge slots, clock low phase and idle level.
// Assumes the host's default SCL_HALF of 4 and the link seen from the reference clock.
`timescale 1ns/1ps
module tcs_link_properties #(
  parameter int unsigned SCL_HALF = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  import tcs_pkg::*;
  localparam int unsigned PAIR12 = 49;
  localparam int unsigned PAIR8 = 40;
  logic scl_q, sda_q, frame_q, rw_q, prev_rw_q;
  logic [7:0] rise_q, lo_q, prev_len_q, age_q;
  logic start_w, stop_w, rise_w;
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  assign rise_w = scl && !scl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Helper state, sampled on the reference clock
  always_ff @(posedge i_ref_clk) begin
    scl_q <= !i_nrst || scl;
    sda_q <= !i_nrst || sda;
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || stop_w) begin
      frame_q <= 1'h0;
    end else if (start_w) begin
      frame_q <= 1'h1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || start_w) begin
      rise_q <= 8'h00;
    end else if (rise_w && frame_q) begin
      rise_q <= rise_q + 8'h01;
    end
  end
  // Eighth bit of the address byte is the direction
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rw_q <= 1'h0;
    end else if (rise_w && frame_q && rise_q == 8'h07) begin
      rw_q <= sda;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      prev_rw_q <= 1'h1;
      prev_len_q <= 8'h00;
    end else if (stop_w && frame_q) begin
      prev_rw_q <= rw_q;
      prev_len_q <= rise_q + 8'h01;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    lo_q <= (!i_nrst || scl) ? 8'h00 : lo_q + 8'h01;
  end
  // Scl still toggles from reset for a cycle or two after release
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      age_q <= 8'h00;
    end else if (age_q != 8'h03) begin
      age_q <= age_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  // Fixed at eight samples: only valid for the default half period of four
  sequence ack_hold_s;
    !scl ##0 dev_sda_oe[*8];
  endsequence
  sequence frame_end_s;
    stop_w && frame_q;
  endsequence

  wr_len_a: assert property (frame_end_s ##0 !rw_q |-> rise_q + 1 == WR_SCL)
    else $error("write frame length wrong");
  rd_len_a: assert property (frame_end_s ##0 rw_q |-> rise_q + 1 inside {RD12_SCL, RD8_SCL})
    else $error("read frame length wrong");
  pair_cost_a: assert property (frame_end_s ##0 (rw_q && !prev_rw_q) |->
    prev_len_q + rise_q + 1 inside {PAIR12, PAIR8})
    else $error("write plus read cost wrong");
  addr_ack_a: assert property (rise_w && frame_q && rise_q == 8'h08 |-> !sda && dev_sda_oe)
    else $error("address not acknowledged");
  cmd_ack_a: assert property (rise_w && frame_q && !rw_q && rise_q == 8'h11 |-> !sda && dev_sda_oe)
    else $error("command not acknowledged");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data moved while clock high");
  ack_hold_a: assert property ($rose(dev_sda_oe) |-> ack_hold_s)
    else $error("device bit not held a full period");
  lo_time_a: assert property ($rose(scl) && frame_q |-> lo_q == SCL_HALF)
    else $error("clock low phase wrong");
  idle_high_a: assert property (age_q == 8'h03 && !frame_q |-> scl)
    else $error("clock not idle high");
endmodule // tcs_link_properties

// *** tb/tb_touch_conversion_sequencer.sv ***
// Testbench: host and converter joined by the link; host user side and samples driven here.
// Assumes default host SCL_HALF and a 20 MHz reference clock on both ends.
`timescale 1ns/1ps
module tb_touch_conversion_sequencer;
  import tcs_pkg::*;
  localparam int LIMIT = 30000;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [11:0] adc;
  logic wr_req = 1'h0;
  logic [7:0] wr_cmd = 8'h00;
  logic rd_req = 1'h0;
  logic rd_8bit = 1'h0;
  logic strobe, dev_busy, byp, res8, h_busy, done, nack, rd_valid;
  logic [11:0] rd_data;
  logic [3:0] fn_tab [8] = '{4'hC, 4'hD, 4'hE, 4'hF, 4'h0, 4'h2, 4'h4, 4'h8};
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [11:0] exp_q [$];
  logic [11:0] smp_q [$];

  always #25 clk = ~clk;
  tcs_link_if tcs_link_if_inst ();
  tcs_device tcs_device_inst (.i_ref_clk(clk), .i_nrst(nrst), .i_adc_data(adc), .o_sample_strobe(strobe),
    .o_busy(dev_busy), .o_filter_bypass(byp), .o_res_8bit(res8), .link(tcs_link_if_inst.dev));
  tcs_host tcs_host_inst (.i_ref_clk(clk), .i_nrst(nrst), .i_wr_req(wr_req), .i_wr_cmd(wr_cmd),
    .i_rd_req(rd_req), .i_rd_8bit(rd_8bit), .o_busy(h_busy), .o_done(done), .o_nack(nack),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .link(tcs_link_if_inst.host));
  tcs_link_properties tcs_link_properties_inst (.i_ref_clk(clk), .i_nrst(nrst), .scl(tcs_link_if_inst.scl),
    .sda(tcs_link_if_inst.sda), .dev_sda_oe(tcs_link_if_inst.dev_sda_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One request held over the edge that takes it, then wait for the end of the frame
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic r8);
    int n;
    n = 0;
    @(posedge clk);
    #2;
    wr_req = wr;
    rd_req = !wr;
    wr_cmd = cmd;
    rd_8bit = r8;
    @(posedge clk);
    #2;
    wr_req = 1'h0;
    rd_req = 1'h0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'h1 && n < 4000);
    check("nack", 32'(nack), 32'h0000_0000);
  endtask

  task automatic measure(input logic m8, input logic bp, input logic setup, input logic [3:0] fn);
    int n;
    int tk;
    int sum;
    logic [11:0] mn;
    logic [11:0] mx;
    logic [11:0] e;
    n = 0;
    if (setup) begin
      xfer(1'h1, ({4'h0, SETUP_FN} << FN_LSB) | (8'(bp) << FILT_BIT), 1'h0);
    end
    smp_q.delete();
    xfer(1'h1, ({4'h0, fn} << FN_LSB) | (8'(m8) << MODE_BIT), 1'h0);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (dev_busy === 1'h1 && n < 2000);
    tk = m8 ? CONV_CYC_8 : CONV_CYC_12;
    tk = bp ? tk - OVERLAP_CYC : tk * CONV_REPS + FILT_CYC - OVERLAP_CYC;
    // Stop-to-start sync and the one-tick phase slack widen the window
    check("conv_time", 32'(n >= tk * CONVERSION_CLOCK_DIV - 8 && n <= tk * CONVERSION_CLOCK_DIV + 10), 32'h0000_0001);
    check("samples", 32'(smp_q.size()), bp ? 32'h0000_0001 : 32'(CONV_REPS));
    check("res8", 32'(res8), 32'(m8));
    check("bypass", 32'(byp), 32'(bp));
    e = 12'h000;
    if (smp_q.size() > 0) begin
      // The filter works on samples already cut to the chosen resolution
      foreach (smp_q[k]) begin
        smp_q[k] = m8 ? (smp_q[k] & RES8_MASK) : smp_q[k];
      end
      e = smp_q[0];
      sum = 0;
      mn = smp_q[0];
      mx = smp_q[0];
      foreach (smp_q[k]) begin
        sum += int'(smp_q[k]);
        mn = (smp_q[k] < mn) ? smp_q[k] : mn;
        mx = (smp_q[k] > mx) ? smp_q[k] : mx;
      end
      if (!bp) begin
        e = 12'((sum - int'(mn) - int'(mx)) / TRIM_DIV);
      end
    end
    exp_q.push_back(m8 ? (e & RES8_MASK) : e);
    xfer(1'h0, 8'h00, m8);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sample taken on the strobe; a fresh random value follows
  always @(posedge clk) begin
    if (strobe === 1'h1) begin
      smp_q.push_back(adc);
      #2;
      adc = 12'($urandom);
    end
  end

  always @(posedge clk) begin
    if (rd_valid === 1'h1) begin
      if (exp_q.size() == 0) begin
        check("rd_extra", 32'h0000_0001, 32'h0000_0000);
      end else begin
        check("rd_data", 32'(rd_data), 32'(exp_q.pop_front()));
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      finish_test();
    end
  end

  // Odd passes skip the setup write, so the bypass choice must persist
  initial begin
    adc = 12'h000;
    void'($urandom(2968));
    repeat (8) @(posedge clk);
    #2;
    nrst = 1'h1;
    adc = 12'($urandom);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      measure(i[0], i[1], !i[0], fn_tab[i]);
    end
    repeat (4) @(posedge clk);
    check("left_over", 32'(exp_q.size()), 32'h0000_0000);
    finish_test();
  end
endmodule // tb_touch_conversion_sequencer
